// ===== verilog/hbf_regs.svh
// register offsets, field positions, reset values and filter counts of the bridge control block
`ifndef HBF_REGS_SVH
`define HBF_REGS_SVH

// byte offsets on the register bus
`define HBF_CTRL_OFS 8'h00
`define HBF_STAT_OFS 8'h04
`define HBF_CLR_OFS 8'h08
`define HBF_FSCFG_OFS 8'h0C

// control register fields
`define HBF_CTRL_VDA 0
`define HBF_CTRL_VDB 1
`define HBF_CTRL_SRC 2
`define HBF_CTRL_MODE 3
`define HBF_CTRL_ALLOW 4
`define HBF_CTRL_W 5
`define HBF_CTRL_RST 5'h18

// status, clear and fault-pin mask fields (shared positions)
`define HBF_ST_WARN 0
`define HBF_ST_OT 1
`define HBF_ST_UV 2
`define HBF_ST_OV 3
`define HBF_ST_SCA 4
`define HBF_ST_SCB 5
`define HBF_ST_FSN 6
`define HBF_ST_UVL 7
`define HBF_ST_OVL 8
`define HBF_ST_ACT 9
`define HBF_ST_W 10
`define HBF_FSCFG_RST 6'h3E

// bus responses
`define HBF_RESP_OKAY 2'h0
`define HBF_RESP_SLVERR 2'h2

// clock period and filter times
`define HBF_CLK_NS 10
`define HBF_OT_FILT_NS 11000
`define HBF_UV_FILT_NS 10000
`define HBF_OV_FILT_NS 3000
`define HBF_OT_FILT_CYC (`HBF_OT_FILT_NS / `HBF_CLK_NS)
`define HBF_UV_FILT_CYC (`HBF_UV_FILT_NS / `HBF_CLK_NS)
`define HBF_OV_FILT_CYC (`HBF_OV_FILT_NS / `HBF_CLK_NS)
`define HBF_SC_FILT_CYC 1

`endif

// ===== verilog/hbf_pkg.sv
// types shared by the bridge control block
package hbf_pkg;

  typedef struct packed {
    logic ot_warn;
    logic ot_over;
    logic ot_cool;
    logic uv;
    logic ov;
    logic sc_a;
    logic sc_b;
  } hbf_sense_s;

  typedef struct packed {
    logic drv;
    logic oe;
  } hbf_leg_s;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } hbf_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hbf_axi_rsp_s;

  typedef enum logic [4:0] {
    HBF_R_NONE = 5'h01,
    HBF_R_CTRL = 5'h02,
    HBF_R_STAT = 5'h04,
    HBF_R_CLR = 5'h08,
    HBF_R_FSCFG = 5'h10
  } hbf_reg_e;

endpackage : hbf_pkg

// ===== verilog/hbf_filt.sv
// persistence filter: output follows the input only after it differs for a full count
`timescale 1ns/1ps
module hbf_filt #(
  parameter int unsigned CNT = 1
) (
  input wire logic clk_sys_i, // system clock
  input wire logic sys_rst_i, // sync reset, active high
  input wire logic ce_i, // clock enable
  input wire logic raw_i, // unfiltered condition
  output logic filt_o // qualified condition
);
  localparam int unsigned W = (CNT > 1) ? $clog2(CNT) : 1;
  localparam logic [W-1:0] LAST = W'(CNT - 1);

  logic [W-1:0] cnt_q;
  logic filt_q;

  // a glitch shorter than the count restarts it, so it never qualifies
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
      filt_q <= 1'b0;
    end else if (ce_i) begin
      if (raw_i == filt_q) begin
        cnt_q <= '0;
      end else if (cnt_q == LAST) begin
        cnt_q <= '0;
        filt_q <= raw_i;
      end else begin
        cnt_q <= cnt_q + W'(1);
      end
    end
  end

  assign filt_o = filt_q;
endmodule : hbf_filt

// ===== verilog/hbf_ctrl.sv
// bridge output mapping, fault latching and register slave of the motor driver
// Functional notes
// [RULE1] Warning temperature sets a warning flag; bridge keeps switching.
// [RULE2] Warning status is live, never latched, clears when temperature falls.
// [RULE3] Shutdown temperature held for filter time latches legs off, sets overheat bit.
// [RULE4] Overheat latch clears only by a clear action after cooling by hysteresis.
// [RULE5] Half-bridge: each leg follows its own direction input.
// [RULE6] Full-bridge, input B high: leg A follows input A, leg B its inverse.
// [RULE7] Full-bridge, input B low: both legs drive high.
// [RULE8] Open direction inputs read as low.
// [RULE9] Legs run only with allow bit set and shutoff low; shutoff high tri-states, fault low.
// [RULE10] Shutoff, sleep pin or software clear latches; sleep low tri-states, fault high.
// [RULE11] Undervoltage tri-states legs, fault low; recovery resumes, fault stays low.
// [RULE12] Full-bridge overvoltage drives both legs high, latches fault low until cleared.
// [RULE13] Half-bridge overvoltage leaves the legs unchanged.
// [RULE14] Short circuit or overheat latches legs tri-state and pulls fault low.
// [RULE15] Full-bridge short stops both legs; half-bridge only the shorted leg.
// [RULE16] Source select set: virtual drive bits replace the direction pins.
// [RULE17] Software can change which faults pull the fault pin low.
// [RULE18] Mode bit one selects full-bridge, zero half-bridge.
// [RULE19] Clearing the allow bit tri-states both legs.
// [RULE20] Fault conditions qualify only after persisting a full clock count.
// [RULE21] Fault pin low while any latched flag set, high when all cleared.
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "hbf_regs.svh"
module hbf_ctrl #(
  parameter int unsigned OT_FILT = `HBF_OT_FILT_CYC,
  parameter int unsigned UV_FILT = `HBF_UV_FILT_CYC,
  parameter int unsigned OV_FILT = `HBF_OV_FILT_CYC,
  parameter int unsigned SC_FILT = `HBF_SC_FILT_CYC
) (
  input wire logic clk_sys_i, // system clock
  input wire logic sys_rst_i, // sync reset, active high
  input wire logic ce_i, // clock enable, freezes all state when low
  input wire logic sleep_wake_pin_i, // high = awake
  input wire logic shutoff_pin_i, // high = outputs off
  input wire logic direction_pin_a_i, // direction input a
  input wire logic direction_pin_b_i, // direction input b
  input wire hbf_pkg::hbf_sense_s sense_i, // raw supply, heat, short sensors
  input wire hbf_pkg::hbf_axi_req_s axi_i, // register bus requests
  output hbf_pkg::hbf_axi_rsp_s axi_o, // register bus answers
  output hbf_pkg::hbf_leg_s bridge_leg_a_o, // leg a level and enable
  output hbf_pkg::hbf_leg_s bridge_leg_b_o, // leg b level and enable
  output logic fault_status_n_o // fault status, active low
);

  // ---------------- register decode ----------------
  function automatic hbf_pkg::hbf_reg_e reg_sel(input logic [31:0] addr);
    hbf_pkg::hbf_reg_e sel;
    sel = hbf_pkg::HBF_R_NONE;
    if (addr[31:8] == 24'h000000) begin
      case (addr[7:0])
        `HBF_CTRL_OFS: sel = hbf_pkg::HBF_R_CTRL;
        `HBF_STAT_OFS: sel = hbf_pkg::HBF_R_STAT;
        `HBF_CLR_OFS: sel = hbf_pkg::HBF_R_CLR;
        `HBF_FSCFG_OFS: sel = hbf_pkg::HBF_R_FSCFG;
        default: sel = hbf_pkg::HBF_R_NONE;
      endcase
    end
    return sel;
  endfunction : reg_sel

  // maps the two drive inputs onto the legs for the selected bridge mode
  function automatic logic [1:0] leg_map(input logic full, input logic da, input logic db);
    logic [1:0] lv;
    lv = {da, db}; // RULE5
    if (full) begin // RULE18
      if (db) begin
        lv = {da, ~da}; // RULE6
      end else begin
        lv = 2'h3; // RULE7
      end
    end
    return lv;
  endfunction : leg_map

  // ---------------- bus slave state ----------------
  logic aw_hold_q;
  logic [31:0] aw_addr_q;
  logic w_hold_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_fire;
  hbf_pkg::hbf_reg_e wr_sel;
  hbf_pkg::hbf_reg_e rd_sel;

  // ---------------- block state ----------------
  logic [`HBF_CTRL_W-1:0] ctrl_q;
  logic [5:0] fs_mask_q;
  logic ot_lat_q;
  logic uv_lat_q;
  logic ov_lat_q;
  logic sca_lat_q;
  logic scb_lat_q;
  hbf_pkg::hbf_leg_s leg_a_q;
  hbf_pkg::hbf_leg_s leg_b_q;
  logic fsn_q;

  logic ot_f;
  logic uv_f;
  logic ov_f;
  logic sca_f;
  logic scb_f;
  logic [5:0] sw_clr;
  logic pin_clr;
  logic clr_ot;
  logic active;
  logic drv_a;
  logic drv_b;
  logic [1:0] lv;
  logic full;
  logic [`HBF_ST_W-1:0] status;
  hbf_pkg::hbf_leg_s leg_a_d;
  hbf_pkg::hbf_leg_s leg_b_d;
  logic fsn_d;

  // ---------------- AXI4-Lite slave ----------------
  // one write and one read at a time; address and data may come in either order
  assign axi_o.awready = ce_i & ~aw_hold_q & ~bvalid_q;
  assign axi_o.wready = ce_i & ~w_hold_q & ~bvalid_q;
  assign axi_o.arready = ce_i & ~rvalid_q;
  assign axi_o.bvalid = bvalid_q;
  assign axi_o.bresp = bresp_q;
  assign axi_o.rvalid = rvalid_q;
  assign axi_o.rdata = rdata_q;
  assign axi_o.rresp = rresp_q;

  assign aw_take = axi_i.awvalid & axi_o.awready;
  assign w_take = axi_i.wvalid & axi_o.wready;
  assign ar_take = axi_i.arvalid & axi_o.arready;
  assign wr_fire = ce_i & aw_hold_q & w_hold_q & ~bvalid_q;
  assign wr_sel = reg_sel(aw_addr_q);
  assign rd_sel = reg_sel(axi_i.araddr);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 32'h00000000;
      w_hold_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (ce_i) begin
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= axi_i.awaddr;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        w_data_q <= axi_i.wdata;
        w_strb_q <= axi_i.wstrb;
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= `HBF_RESP_OKAY;
    end else if (ce_i) begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= (wr_sel == hbf_pkg::HBF_R_NONE) ? `HBF_RESP_SLVERR : `HBF_RESP_OKAY;
      end else if (axi_i.bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `HBF_RESP_OKAY;
    end else if (ce_i) begin
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rresp_q <= `HBF_RESP_OKAY;
        case (rd_sel)
          hbf_pkg::HBF_R_CTRL: rdata_q <= {27'h0000000, ctrl_q};
          hbf_pkg::HBF_R_STAT: rdata_q <= {22'h000000, status}; // RULE2
          hbf_pkg::HBF_R_FSCFG: rdata_q <= {26'h0000000, fs_mask_q};
          hbf_pkg::HBF_R_CLR: rdata_q <= 32'h00000000;
          default: begin
            rdata_q <= 32'h00000000;
            rresp_q <= `HBF_RESP_SLVERR;
          end
        endcase
      end else if (axi_i.rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ---------------- software registers ----------------
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ctrl_q <= `HBF_CTRL_RST;
    end else if (wr_fire && wr_sel == hbf_pkg::HBF_R_CTRL && w_strb_q[0]) begin
      ctrl_q <= w_data_q[`HBF_CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      fs_mask_q <= `HBF_FSCFG_RST;
    end else if (wr_fire && wr_sel == hbf_pkg::HBF_R_FSCFG && w_strb_q[0]) begin
      fs_mask_q <= w_data_q[5:0]; // RULE17
    end
  end

  // write-one-to-clear strobe for the latched flags
  assign sw_clr = (wr_fire && wr_sel == hbf_pkg::HBF_R_CLR && w_strb_q[0]) ? w_data_q[5:0] : 6'h00;

  // ---------------- sensor filters ----------------
  hbf_filt #(.CNT(OT_FILT)) u_ot_filt ( // RULE3
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .raw_i(sense_i.ot_over),
    .filt_o(ot_f)
  );

  hbf_filt #(.CNT(UV_FILT)) u_uv_filt ( // RULE20
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .raw_i(sense_i.uv),
    .filt_o(uv_f)
  );

  hbf_filt #(.CNT(OV_FILT)) u_ov_filt ( // RULE20
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .raw_i(sense_i.ov),
    .filt_o(ov_f)
  );

  hbf_filt #(.CNT(SC_FILT)) u_sca_filt ( // RULE20
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .raw_i(sense_i.sc_a),
    .filt_o(sca_f)
  );

  hbf_filt #(.CNT(SC_FILT)) u_scb_filt ( // RULE20
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .raw_i(sense_i.sc_b),
    .filt_o(scb_f)
  );

  // ---------------- fault latches ----------------
  // holding shutoff high or sleep low clears latches; a set in the same cycle still wins
  assign pin_clr = shutoff_pin_i | ~sleep_wake_pin_i; // RULE10
  // the overheat latch cannot be released until the die has cooled by the hysteresis
  assign clr_ot = (sw_clr[`HBF_ST_OT] | pin_clr) & sense_i.ot_cool; // RULE4
  assign full = ctrl_q[`HBF_CTRL_MODE];

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ot_lat_q <= 1'b0;
      uv_lat_q <= 1'b0;
      ov_lat_q <= 1'b0;
    end else if (ce_i) begin
      ot_lat_q <= ot_f | (ot_lat_q & ~clr_ot); // RULE3
      uv_lat_q <= uv_f | (uv_lat_q & ~(sw_clr[`HBF_ST_UV] | pin_clr)); // RULE11
      ov_lat_q <= ov_f | (ov_lat_q & ~(sw_clr[`HBF_ST_OV] | pin_clr)); // RULE12
    end
  end

  // shorts only count while the stage is actually driving
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sca_lat_q <= 1'b0;
      scb_lat_q <= 1'b0;
    end else if (ce_i) begin
      sca_lat_q <= (sca_f & leg_a_q.oe) | (sca_lat_q & ~(sw_clr[`HBF_ST_SCA] | pin_clr)); // RULE14
      scb_lat_q <= (scb_f & leg_b_q.oe) | (scb_lat_q & ~(sw_clr[`HBF_ST_SCB] | pin_clr)); // RULE14
    end
  end

  // ---------------- output mapping ----------------
  // open pins are pulled low outside, so they arrive here as zero
  assign drv_a = ctrl_q[`HBF_CTRL_SRC] ? ctrl_q[`HBF_CTRL_VDA] : direction_pin_a_i; // RULE16 RULE8
  assign drv_b = ctrl_q[`HBF_CTRL_SRC] ? ctrl_q[`HBF_CTRL_VDB] : direction_pin_b_i; // RULE16 RULE8
  assign lv = leg_map(full, drv_a, drv_b);

  // the warning flag has no path into this term, so the bridge keeps running
  assign active = sleep_wake_pin_i & ~shutoff_pin_i & ctrl_q[`HBF_CTRL_ALLOW] // RULE9 RULE19 RULE1
                & ~uv_f & ~ot_lat_q; // RULE11 RULE14

  always_comb begin
    leg_a_d.drv = lv[1];
    leg_b_d.drv = lv[0];
    if (full && ov_f) begin
      leg_a_d.drv = 1'b1; // RULE12
      leg_b_d.drv = 1'b1;
    end
    // half-bridge overvoltage latches its flag and can pull the fault pin, but the legs are left alone: the mapping above stays in force
    if (full) begin // RULE13
      leg_a_d.oe = active & ~sca_lat_q & ~scb_lat_q; // RULE15
      leg_b_d.oe = active & ~sca_lat_q & ~scb_lat_q;
    end else begin
      leg_a_d.oe = active & ~sca_lat_q; // RULE15
      leg_b_d.oe = active & ~scb_lat_q;
    end
  end

  // ---------------- fault status pin ----------------
  always_comb begin
    if (!sleep_wake_pin_i) begin
      fsn_d = 1'b1; // RULE10
    end else if (shutoff_pin_i || !ctrl_q[`HBF_CTRL_ALLOW]) begin
      fsn_d = 1'b0; // RULE9
    end else begin
      fsn_d = ~(|(fs_mask_q & {scb_lat_q, sca_lat_q, ov_lat_q, uv_lat_q, ot_lat_q, 1'b0})); // RULE21 RULE17
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      leg_a_q <= '0;
      leg_b_q <= '0;
      fsn_q <= 1'b1;
    end else if (ce_i) begin
      leg_a_q <= leg_a_d;
      leg_b_q <= leg_b_d;
      fsn_q <= fsn_d;
    end
  end

  assign bridge_leg_a_o = leg_a_q;
  assign bridge_leg_b_o = leg_b_q;
  assign fault_status_n_o = fsn_q;

  // ---------------- status word ----------------
  always_comb begin
    status = '0;
    status[`HBF_ST_WARN] = sense_i.ot_warn; // RULE1 RULE2
    status[`HBF_ST_OT] = ot_lat_q;
    status[`HBF_ST_UV] = uv_lat_q;
    status[`HBF_ST_OV] = ov_lat_q;
    status[`HBF_ST_SCA] = sca_lat_q;
    status[`HBF_ST_SCB] = scb_lat_q;
    status[`HBF_ST_FSN] = fsn_q;
    status[`HBF_ST_UVL] = uv_f;
    status[`HBF_ST_OVL] = ov_f;
    status[`HBF_ST_ACT] = active;
  end

endmodule : hbf_ctrl

// ===== bench/hbf_ctrl_properties.sv
// concurrent checks on the ports of the bridge control block
`timescale 1ns/1ps
`include "hbf_regs.svh"
module hbf_ctrl_properties #(
  parameter int unsigned OT_FILT = 4,
  parameter int unsigned UV_FILT = 4,
  parameter int unsigned OV_FILT = 4,
  parameter int unsigned SC_FILT = 1
) (
  input wire logic clk_sys_i, // system clock
  input wire logic sys_rst_i, // sync reset
  input wire logic ce_i, // clock enable
  input wire logic sleep_wake_pin_i, // sleep pin
  input wire logic shutoff_pin_i, // shutoff pin
  input wire logic direction_pin_a_i, // direction a
  input wire logic direction_pin_b_i, // direction b
  input wire hbf_pkg::hbf_sense_s sense_i, // sensors
  input wire hbf_pkg::hbf_axi_req_s axi_i, // bus requests
  input wire hbf_pkg::hbf_axi_rsp_s axi_o, // bus answers
  input wire hbf_pkg::hbf_leg_s bridge_leg_a_o, // leg a
  input wire hbf_pkg::hbf_leg_s bridge_leg_b_o, // leg b
  input wire logic fault_status_n_o // fault pin
);
  logic [4:0] ctl_q, ctl_r;
  logic [1:0] eff_q;
  logic mode_q, allow_q, ctl_wr;
  logic [7:0] ot_q, uv_q, ov_q, ovl_q;
  // shadow of the control register, one cycle early since the bus slave commits it a cycle after the handshake
  assign ctl_wr = axi_i.awvalid && axi_o.awready && axi_i.wvalid && axi_o.wready && axi_i.wstrb[0]
    && axi_i.awaddr == {24'h000000, `HBF_CTRL_OFS};
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ctl_q <= `HBF_CTRL_RST;
      ctl_r <= `HBF_CTRL_RST;
      eff_q <= 2'h0;
      mode_q <= 1'b1;
      allow_q <= 1'b1;
      ot_q <= 8'h00;
      uv_q <= 8'h00;
      ov_q <= 8'h00;
      ovl_q <= 8'h00;
    end else if (ce_i) begin
      if (ctl_wr) begin
        ctl_q <= axi_i.wdata[4:0];
      end
      ctl_r <= ctl_q;
      eff_q <= ctl_r[2] ? ctl_r[1:0] : {direction_pin_b_i, direction_pin_a_i};
      mode_q <= ctl_r[3];
      allow_q <= ctl_r[4];
      ot_q <= sense_i.ot_over ? ot_q + 8'h01 : 8'h00;
      uv_q <= sense_i.uv ? uv_q + 8'h01 : 8'h00;
      ov_q <= sense_i.ov ? ov_q + 8'h01 : 8'h00;
      ovl_q <= sense_i.ov ? 8'h00 : ovl_q + 8'h01;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i || !ce_i);
  sequence legs_off_s;
    !bridge_leg_a_o.oe && !bridge_leg_b_o.oe;
  endsequence
  sleep_low_a: assert property (!sleep_wake_pin_i |=> fault_status_n_o ##0 legs_off_s)
    else $error("sleep low but legs on or fault pin low");
  shutoff_high_a: assert property (sleep_wake_pin_i && shutoff_pin_i |=> !fault_status_n_o ##0 legs_off_s)
    else $error("shutoff high but legs on or fault pin high");
  allow_off_a: assert property (!allow_q && $past(sleep_wake_pin_i) |-> !fault_status_n_o ##0 legs_off_s)
    else $error("allow bit clear but legs on");
  overheat_trip_a: assert property (ot_q == OT_FILT |-> ##[1:3] legs_off_s)
    else $error("overheat held for filter time but legs on");
  undervolt_trip_a: assert property (uv_q == UV_FILT |-> ##[1:2] legs_off_s)
    else $error("undervoltage held for filter time but legs on");
  short_trip_a: assert property (sense_i.sc_a && bridge_leg_a_o.oe |-> ##[1:3] !bridge_leg_a_o.oe)
    else $error("short on leg a did not stop it");
  ov_force_a: assert property (mode_q && ov_q > OV_FILT && bridge_leg_a_o.oe |->
    bridge_leg_a_o.drv && bridge_leg_b_o.drv) else $error("overvoltage in full bridge but legs not high");
  full_map_a: assert property (mode_q && bridge_leg_a_o.oe && ovl_q > OV_FILT |->
    bridge_leg_a_o.drv == (eff_q[1] ? eff_q[0] : 1'b1) && bridge_leg_b_o.drv == (eff_q[1] ? !eff_q[0] : 1'b1))
    else $error("full bridge legs do not match inputs");
  half_map_a: assert property (!mode_q && bridge_leg_a_o.oe |-> bridge_leg_a_o.drv == eff_q[0])
    else $error("half bridge leg a does not follow its input");
endmodule : hbf_ctrl_properties

bind hbf_ctrl hbf_ctrl_properties #(.OT_FILT(OT_FILT), .UV_FILT(UV_FILT), .OV_FILT(OV_FILT), .SC_FILT(SC_FILT))
  i_hbf_ctrl_properties (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
  .sleep_wake_pin_i(sleep_wake_pin_i), .shutoff_pin_i(shutoff_pin_i), .direction_pin_a_i(direction_pin_a_i),
  .direction_pin_b_i(direction_pin_b_i), .sense_i(sense_i), .axi_i(axi_i), .axi_o(axi_o),
  .bridge_leg_a_o(bridge_leg_a_o), .bridge_leg_b_o(bridge_leg_b_o), .fault_status_n_o(fault_status_n_o));

// ===== bench/hbf_host.sv
// host controller model driving the control pins of the bridge block
`timescale 1ns/1ps
module hbf_host (
  output logic sleep_wake_pin_o, // high = awake
  output logic shutoff_pin_o, // high = outputs off
  output logic direction_pin_a_o, // direction a
  output logic direction_pin_b_o // direction b
);
  initial begin
    sleep_wake_pin_o = 1'b1;
    shutoff_pin_o = 1'b0;
    direction_pin_a_o = 1'b0;
    direction_pin_b_o = 1'b0;
  end
  // called just after a clock edge, so pins never move on the sampling edge
  task pins(input logic s, input logic off, input logic a, input logic b);
    sleep_wake_pin_o <= s;
    shutoff_pin_o <= off;
    direction_pin_a_o <= a;
    direction_pin_b_o <= b;
  endtask : pins
  // open pins take the level their internal pulls give them
  task open_pins;
    sleep_wake_pin_o <= 1'b0;
    shutoff_pin_o <= 1'b1;
    direction_pin_a_o <= 1'b0;
    direction_pin_b_o <= 1'b0;
  endtask : open_pins
endmodule : hbf_host

// ===== bench/hbf_ctrl_bench.sv
// self-checking bench for the bridge control block
`timescale 1ns/1ps
`include "hbf_regs.svh"
module hbf_ctrl_bench;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ce_q = 1'b1;
  logic sleep_w, off_w, dir_a_w, dir_b_w, fault_n;
  hbf_pkg::hbf_sense_s sense_q = hbf_pkg::hbf_sense_s'(7'h10);
  hbf_pkg::hbf_axi_req_s axi_q = '0;
  hbf_pkg::hbf_axi_rsp_s axi_r;
  hbf_pkg::hbf_leg_s leg_a, leg_b;
  int mismatches = 0;
  int tests_run = 0;
  hbf_host i_host (.sleep_wake_pin_o(sleep_w), .shutoff_pin_o(off_w), .direction_pin_a_o(dir_a_w),
    .direction_pin_b_o(dir_b_w));
  // short filters keep the fault scenarios brief
  hbf_ctrl #(.OT_FILT(4), .UV_FILT(4), .OV_FILT(4), .SC_FILT(1)) i_hbf_ctrl (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .ce_i(ce_q), .sleep_wake_pin_i(sleep_w), .shutoff_pin_i(off_w),
    .direction_pin_a_i(dir_a_w), .direction_pin_b_i(dir_b_w), .sense_i(sense_q), .axi_i(axi_q), .axi_o(axi_r),
    .bridge_leg_a_o(leg_a), .bridge_leg_b_o(leg_b), .fault_status_n_o(fault_n));
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task summarize;
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  task cmp_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: bus word %h, expected %h", $time, got, exp);
    end
  endtask : cmp_word
  // legs compared as {oe_a, drv_a, oe_b, drv_b, fault}; level ignored while tri-stated
  task chk_out(input logic [4:0] exp);
    logic [4:0] got;
    repeat (3) @(posedge clk_sys_i);
    got = {leg_a.oe, leg_a.oe & leg_a.drv, leg_b.oe, leg_b.oe & leg_b.drv, fault_n};
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: outputs %b, expected %b", $time, got, exp);
    end
  endtask : chk_out
  function automatic logic [4:0] outs(input logic oe, input logic a, input logic b, input logic f);
    return {oe, oe & a, oe, oe & b, f};
  endfunction : outs
  task sns(input logic [6:0] v, input int n);
    sense_q <= hbf_pkg::hbf_sense_s'(v);
    repeat (n) @(posedge clk_sys_i);
  endtask : sns
  // waits for the answer however long it takes; only the watchdog ends a hung transfer
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    axi_q.awaddr <= {24'h000000, a};
    axi_q.wdata <= d;
    axi_q.wstrb <= 4'hF;
    axi_q.awvalid <= 1'b1;
    axi_q.wvalid <= 1'b1;
    axi_q.bready <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (axi_r.awready) axi_q.awvalid <= 1'b0;
      if (axi_r.wready) axi_q.wvalid <= 1'b0;
    end while (!axi_r.bvalid);
    axi_q.bready <= 1'b0;
    cmp_word({30'h0, axi_r.bresp}, {30'h0, er});
    @(posedge clk_sys_i);
  endtask : axi_wr
  task axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    axi_q.araddr <= {24'h000000, a};
    axi_q.arvalid <= 1'b1;
    axi_q.rready <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (axi_r.arready) axi_q.arvalid <= 1'b0;
    end while (!axi_r.rvalid);
    axi_q.rready <= 1'b0;
    cmp_word(axi_r.rdata & m, e & m);
    cmp_word({30'h0, axi_r.rresp}, {30'h0, er});
    @(posedge clk_sys_i);
  endtask : axi_rd
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    mismatches++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    axi_rd(`HBF_CTRL_OFS, 32'hFFFFFFFF, 32'h00000018, `HBF_RESP_OKAY);
    axi_rd(`HBF_FSCFG_OFS, 32'hFFFFFFFF, 32'h0000003E, `HBF_RESP_OKAY);
    axi_rd(8'h10, 32'hFFFFFFFF, 32'h00000000, `HBF_RESP_SLVERR);
    axi_wr(8'h10, 32'h0000001F, `HBF_RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      i_host.pins(1'b1, 1'b0, i[0], i[1]);
      chk_out(outs(1'b1, i[1] ? i[0] : 1'b1, i[1] ? !i[0] : 1'b1, 1'b1));
    end
    axi_wr(`HBF_CTRL_OFS, 32'h00000010, `HBF_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      i_host.pins(1'b1, 1'b0, i[0], i[1]);
      chk_out(outs(1'b1, i[0], i[1], 1'b1));
    end
    for (int i = 0; i < 4; i++) begin
      axi_wr(`HBF_CTRL_OFS, 32'h00000014 + 32'(i), `HBF_RESP_OKAY);
      i_host.pins(1'b1, 1'b0, !i[0], !i[1]);
      chk_out(outs(1'b1, i[0], i[1], 1'b1));
    end
    axi_wr(`HBF_CTRL_OFS, 32'h00000015, `HBF_RESP_OKAY);
    sns(7'h14, 10);
    chk_out(outs(1'b1, 1'b1, 1'b0, 1'b0));
    sns(7'h10, 10);
    axi_wr(`HBF_CLR_OFS, 32'h00000008, `HBF_RESP_OKAY);
    chk_out(outs(1'b1, 1'b1, 1'b0, 1'b1));
    sns(7'h12, 2);
    sns(7'h10, 0);
    chk_out(5'h04);
    axi_wr(`HBF_CLR_OFS, 32'h00000010, `HBF_RESP_OKAY);
    chk_out(outs(1'b1, 1'b1, 1'b0, 1'b1));
    axi_wr(`HBF_CTRL_OFS, 32'h00000018, `HBF_RESP_OKAY);
    i_host.pins(1'b1, 1'b0, 1'b1, 1'b1);
    sns(7'h14, 10);
    chk_out(outs(1'b1, 1'b1, 1'b1, 1'b0));
    sns(7'h10, 10);
    chk_out(outs(1'b1, 1'b1, 1'b0, 1'b0));
    axi_wr(`HBF_CLR_OFS, 32'h00000008, `HBF_RESP_OKAY);
    chk_out(outs(1'b1, 1'b1, 1'b0, 1'b1));
    sns(7'h11, 2);
    sns(7'h10, 0);
    chk_out(outs(1'b0, 1'b0, 1'b0, 1'b0));
    i_host.pins(1'b1, 1'b1, 1'b1, 1'b1);
    chk_out(outs(1'b0, 1'b0, 1'b0, 1'b0));
    i_host.pins(1'b1, 1'b0, 1'b1, 1'b1);
    chk_out(outs(1'b1, 1'b1, 1'b0, 1'b1));
    // clock enable low must freeze the legs although the pins move
    ce_q <= 1'b0;
    i_host.pins(1'b1, 1'b0, 1'b0, 1'b1);
    chk_out(outs(1'b1, 1'b1, 1'b0, 1'b1));
    ce_q <= 1'b1;
    chk_out(outs(1'b1, 1'b0, 1'b1, 1'b1));
    i_host.pins(1'b1, 1'b0, 1'b1, 1'b1);
    sns(7'h50, 2);
    axi_rd(`HBF_STAT_OFS, 32'h00000001, 32'h00000001, `HBF_RESP_OKAY);
    chk_out(outs(1'b1, 1'b1, 1'b0, 1'b1));
    sns(7'h10, 2);
    axi_rd(`HBF_STAT_OFS, 32'h00000001, 32'h00000000, `HBF_RESP_OKAY);
    sns(7'h20, 8);
    chk_out(outs(1'b0, 1'b0, 1'b0, 1'b0));
    sns(7'h00, 8);
    axi_wr(`HBF_CLR_OFS, 32'h00000002, `HBF_RESP_OKAY);
    axi_rd(`HBF_STAT_OFS, 32'h00000002, 32'h00000002, `HBF_RESP_OKAY);
    sns(7'h10, 2);
    axi_wr(`HBF_CLR_OFS, 32'h00000002, `HBF_RESP_OKAY);
    chk_out(outs(1'b1, 1'b1, 1'b0, 1'b1));
    sns(7'h18, 3);
    sns(7'h10, 0);
    chk_out(outs(1'b1, 1'b1, 1'b0, 1'b1));
    sns(7'h18, 8);
    chk_out(outs(1'b0, 1'b0, 1'b0, 1'b0));
    sns(7'h10, 8);
    chk_out(outs(1'b1, 1'b1, 1'b0, 1'b0));
    axi_wr(`HBF_CLR_OFS, 32'h00000004, `HBF_RESP_OKAY);
    axi_wr(`HBF_FSCFG_OFS, 32'h00000000, `HBF_RESP_OKAY);
    sns(7'h18, 8);
    chk_out(outs(1'b0, 1'b0, 1'b0, 1'b1));
    sns(7'h10, 8);
    axi_wr(`HBF_CLR_OFS, 32'h00000004, `HBF_RESP_OKAY);
    axi_wr(`HBF_FSCFG_OFS, 32'h0000003E, `HBF_RESP_OKAY);
    axi_wr(`HBF_CTRL_OFS, 32'h00000008, `HBF_RESP_OKAY);
    chk_out(outs(1'b0, 1'b0, 1'b0, 1'b0));
    axi_wr(`HBF_CTRL_OFS, 32'h00000018, `HBF_RESP_OKAY);
    i_host.open_pins();
    chk_out(outs(1'b0, 1'b0, 1'b0, 1'b1));
    summarize();
  end
endmodule : hbf_ctrl_bench
